// ==== ies_pkg.sv ====
// package: constants, types and carriers for the interrupt entry and stack pointer unit
package ies_pkg;
   localparam int          IES_NF        = 8;
   localparam int          IES_NL        = 4;
   localparam int          IES_NREQ      = IES_NF + IES_NL;
   localparam int          IES_IDX_W     = 4;
   localparam logic [15:0] IES_TOP_OF_DATA_MEMORY = 16'h02FF;
   localparam logic [15:0] IES_VEC_BASE  = 16'h0000;
   localparam logic [15:0] IES_VEC_STEP  = 16'h0001;
   // io space offsets of the unit
   localparam logic [5:0]  IES_ADR_SPL   = 6'h3D;
   localparam logic [5:0]  IES_ADR_SPH   = 6'h3E;
   localparam logic [5:0]  IES_ADR_FLAGS = 6'h3F;
   localparam logic [5:0]  IES_ADR_PEND  = 6'h1C;
   // field positions and reset values
   localparam int          IES_GIE_BIT   = 7;
   localparam logic [7:0]  IES_FLAGS_RST = 8'h00;
   localparam logic [7:0]  IES_PEND_RST  = 8'h00;
   // durations in ns, clock period and the cycle counts derived from them
   localparam int          IES_ENTRY_NS  = 80;
   localparam int          IES_WAKE_NS   = 80;
   localparam int          IES_EXIT_NS   = 80;
   localparam int          IES_CLK_NS    = 20;
   localparam logic [2:0]  IES_ENTRY_CYC = 3'((IES_ENTRY_NS + IES_CLK_NS - 1) / IES_CLK_NS);
   localparam logic [2:0]  IES_WAKE_CYC  = 3'((IES_WAKE_NS + IES_CLK_NS - 1) / IES_CLK_NS);
   localparam logic [2:0]  IES_EXIT_CYC  = 3'((IES_EXIT_NS + IES_CLK_NS - 1) / IES_CLK_NS);
   localparam logic [2:0]  IES_CNT_RST   = 3'h0;

   typedef enum logic [2:0] {
      IES_CMD_NONE  = 3'h0,
      IES_CMD_PUSH1 = 3'h1,
      IES_CMD_POP1  = 3'h2,
      IES_CMD_CALL  = 3'h3,
      IES_CMD_RET   = 3'h4,
      IES_CMD_IRQ_EXIT_INSTRUCTION  = 3'h5,
      IES_CMD_CLI   = 3'h6,
      IES_CMD_SEI   = 3'h7
   } ies_cmd_e;

   typedef enum logic [3:0] {
      IES_ST_IDLE  = 4'h1,
      IES_ST_WAKE  = 4'h2,
      IES_ST_ENTRY = 4'h4,
      IES_ST_EXIT  = 4'h8
   } ies_state_e;

   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } ies_mem_s;

   localparam ies_mem_s IES_MEM_IDLE = '{we: 1'b0, re: 1'b0, addr: 16'h0000, wdata: 8'h00};
endpackage

// ==== ies_irq_sp.sv ====
// interrupt entry, return sequencing and stack pointer of the core
// Overview of operation
// - byte push lowers stack pointer by one
// - call or entry lowers pointer by two
// - byte pop raises stack pointer by one
// - subroutine or irq exit raises by two
// - pointer as two bytes, reset to top
// - take only with own and global enable
// - lower vector wins, request zero first
// - entry clears global enable, irq exit sets
// - serving a flag request clears its flag
// - writing one clears a pending flag
// - flags latch while disabled until served
// - level requests count only while present
// - one instruction runs after irq exit
// - flags register never saved by hardware
// - global disable acts in same cycle
// - one instruction runs after global enable
// - entry takes four cycles, pushes pc
// - multi-cycle instruction finishes before entry
// - wake from sleep adds four cycles
// - exit takes four cycles, pops pc
// - lock fuses may block requests by pc
`timescale 1ns/1ps
`default_nettype none
module ies_irq_sp
   import ies_pkg::*;
#(
   parameter int          SP_W  = 16,
   parameter logic [15:0] TOP   = IES_TOP_OF_DATA_MEMORY
) (
   input  wire logic              i_sys_clk,
   input  wire logic              i_resetn,
   input  wire logic              i_clk_en,
   input  wire ies_cmd_e          i_cmd,
   input  wire logic              i_insn_done,
   input  wire logic              i_sleeping,
   input  wire logic [15:0]       i_pc,
   input  wire logic [7:0]        i_push_data,
   input  wire logic [IES_NF-1:0] i_flag_cond,
   input  wire logic [IES_NF-1:0] i_flag_en,
   input  wire logic [IES_NL-1:0] i_level_cond,
   input  wire logic [IES_NL-1:0] i_level_en,
   input  wire logic              i_lock_fuse_one,
   input  wire logic              i_lock_fuse_two,
   input  wire logic              i_pc_in_locked_area,
   input  wire logic              i_io_wr,
   input  wire logic [5:0]        i_io_addr,
   input  wire logic [7:0]        i_io_wdata,
   input  wire logic [7:0]        i_mem_rdata,
   output logic [7:0]             o_io_rdata,
   output ies_mem_s               o_mem,
   output logic                   o_pc_load,
   output logic [15:0]            o_pc_value,
   output logic                   o_busy,
   output logic                   o_gie,
   output logic [15:0]            o_sp,
   output logic [IES_NF-1:0]      o_flag_pending
);
   localparam logic [15:0] SP_MASK = 16'((17'h1 << SP_W) - 17'h1);

   // lowest index wins, so index order is vector order
   function automatic logic [IES_IDX_W-1:0] ies_first(input logic [IES_NREQ-1:0] v);
      logic [IES_IDX_W-1:0] r;
      r = '0;
      for (int k = IES_NREQ - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = IES_IDX_W'(k);
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] ies_vec(input logic [IES_IDX_W-1:0] idx);
      return 16'(IES_VEC_BASE + IES_VEC_STEP * (16'(idx) + 16'h0001));
   endfunction

   logic                 rst_s1;
   logic                 rst_s2;
   ies_state_e           state;
   ies_state_e           next_state;
   logic [2:0]           cnt;
   logic [2:0]           next_cnt;
   logic [15:0]          sp;
   logic [15:0]          next_sp;
   logic [7:0]           flags;
   logic [7:0]           next_flags;
   logic [IES_NF-1:0]    pend;
   logic [IES_NF-1:0]    next_pend;
   logic                 hold_off;
   logic                 next_hold_off;
   logic                 is_call;
   logic                 next_is_call;
   logic                 is_irq_exit_instruction;
   logic                 next_is_irq_exit_instruction;
   logic [IES_IDX_W-1:0] sel;
   logic [IES_IDX_W-1:0] next_sel;
   logic [15:0]          pc_save;
   logic [15:0]          next_pc_save;
   logic [7:0]           pc_hi;
   logic [7:0]           next_pc_hi;
   ies_mem_s             next_mem;
   logic                 next_pc_load;
   logic [15:0]          next_pc_value;
   logic [7:0]           next_io_rdata;
   logic [IES_NREQ-1:0]  req;
   logic                 any_req;
   logic                 lock_block;
   logic                 can_take;

   // reset release through two stages
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   always_comb begin
      lock_block = (i_lock_fuse_one | i_lock_fuse_two) & i_pc_in_locked_area;
      req        = {i_level_cond & i_level_en, pend & i_flag_en};
      any_req    = (|req) & ~lock_block;
      // same-cycle disable and hold-off after enable or exit
      can_take   = flags[IES_GIE_BIT] & (i_cmd != IES_CMD_CLI) & ~hold_off & any_req;

      next_state    = state;
      next_cnt      = cnt;
      next_sp       = sp;
      next_flags    = flags;
      next_hold_off = hold_off;
      next_is_call  = is_call;
      next_is_irq_exit_instruction  = is_irq_exit_instruction;
      next_sel      = sel;
      next_pc_save  = pc_save;
      next_pc_hi    = pc_hi;
      next_mem      = IES_MEM_IDLE;
      next_pc_load  = 1'b0;
      next_pc_value = o_pc_value;
      next_pend     = pend;

      // software register writes; hardware sequencing below overrides
      if (i_io_wr) begin
         case (i_io_addr)
            IES_ADR_SPL:   next_sp[7:0]  = i_io_wdata & SP_MASK[7:0];
            IES_ADR_SPH:   next_sp[15:8] = i_io_wdata & SP_MASK[15:8];
            IES_ADR_FLAGS: next_flags    = i_io_wdata;
            IES_ADR_PEND:  next_pend     = pend & ~i_io_wdata[IES_NF-1:0];
            default:       next_pend     = pend;
         endcase
      end
      if (i_insn_done) begin
         next_hold_off = 1'b0;
      end

      case (state)
         IES_ST_IDLE: begin
            next_cnt = IES_CNT_RST;
            if (i_sleeping && any_req) begin
               next_sel     = ies_first(req);
               next_state   = IES_ST_WAKE;
               next_is_call = 1'b0;
            end else if (i_insn_done && can_take) begin
               // boundary only, so a multi-cycle instruction has completed
               next_sel          = ies_first(req);
               next_pc_save      = i_pc;
               next_is_call      = 1'b0;
               next_state        = IES_ST_ENTRY;
               next_flags[IES_GIE_BIT] = 1'b0;
            end else begin
               case (i_cmd)
                  IES_CMD_PUSH1: begin
                     next_mem = '{we: 1'b1, re: 1'b0, addr: sp, wdata: i_push_data};
                     next_sp  = (sp - 16'h0001) & SP_MASK;
                  end
                  IES_CMD_POP1: begin
                     next_mem = '{we: 1'b0, re: 1'b1, addr: (sp + 16'h0001) & SP_MASK,
                                  wdata: 8'h00};
                     next_sp  = (sp + 16'h0001) & SP_MASK;
                  end
                  IES_CMD_CALL: begin
                     next_pc_save = i_pc;
                     next_is_call = 1'b1;
                     next_state   = IES_ST_ENTRY;
                  end
                  IES_CMD_RET, IES_CMD_IRQ_EXIT_INSTRUCTION: begin
                     next_is_irq_exit_instruction = (i_cmd == IES_CMD_IRQ_EXIT_INSTRUCTION);
                     next_state   = IES_ST_EXIT;
                  end
                  IES_CMD_CLI: next_flags[IES_GIE_BIT] = 1'b0;
                  IES_CMD_SEI: begin
                     next_flags[IES_GIE_BIT] = 1'b1;
                     next_hold_off           = 1'b1;
                  end
                  default: next_mem = IES_MEM_IDLE;
               endcase
            end
         end
         IES_ST_WAKE: begin
            next_cnt = cnt + 3'h1;
            if (cnt == IES_WAKE_CYC - 3'h1) begin
               // pending state may have changed while waking
               next_cnt     = IES_CNT_RST;
               next_pc_save = i_pc;
               if (can_take) begin
                  next_sel                = ies_first(req);
                  next_state              = IES_ST_ENTRY;
                  next_flags[IES_GIE_BIT] = 1'b0;
               end else begin
                  next_state = IES_ST_IDLE;
               end
            end
         end
         IES_ST_ENTRY: begin
            next_cnt = cnt + 3'h1;
            case (cnt)
               3'h0: next_mem = '{we: 1'b1, re: 1'b0, addr: sp, wdata: pc_save[7:0]};
               3'h1: begin
                  next_mem = '{we: 1'b1, re: 1'b0, addr: (sp - 16'h0001) & SP_MASK,
                               wdata: pc_save[15:8]};
                  next_sp  = (sp - 16'h0002) & SP_MASK;
               end
               default: next_mem = IES_MEM_IDLE;
            endcase
            if (cnt == IES_ENTRY_CYC - 3'h1) begin
               next_cnt   = IES_CNT_RST;
               next_state = IES_ST_IDLE;
               if (!is_call) begin
                  next_pc_load  = 1'b1;
                  next_pc_value = ies_vec(sel);
                  if (sel < IES_IDX_W'(IES_NF)) begin
                     next_pend[sel[2:0]] = 1'b0;
                  end
               end
            end
         end
         IES_ST_EXIT: begin
            next_cnt = cnt + 3'h1;
            case (cnt)
               3'h0: next_mem = '{we: 1'b0, re: 1'b1, addr: (sp + 16'h0001) & SP_MASK,
                                  wdata: 8'h00};
               3'h1: next_mem = '{we: 1'b0, re: 1'b1, addr: (sp + 16'h0002) & SP_MASK,
                                  wdata: 8'h00};
               3'h2: next_pc_hi = i_mem_rdata;
               default: next_mem = IES_MEM_IDLE;
            endcase
            if (cnt == IES_EXIT_CYC - 3'h1) begin
               next_cnt      = IES_CNT_RST;
               next_state    = IES_ST_IDLE;
               next_pc_load  = 1'b1;
               next_pc_value = {pc_hi, i_mem_rdata};
               next_sp       = (sp + 16'h0002) & SP_MASK;
               // only the enable bit changes, the rest of flags is left alone
               if (is_irq_exit_instruction) begin
                  next_flags[IES_GIE_BIT] = 1'b1;
                  next_hold_off           = 1'b1;
               end
            end
         end
         default: begin
            next_state = IES_ST_IDLE;
            next_cnt   = IES_CNT_RST;
         end
      endcase

      // new events win over any clear in the same cycle
      next_pend = next_pend | i_flag_cond;

      case (i_io_addr)
         IES_ADR_SPL:   next_io_rdata = next_sp[7:0];
         IES_ADR_SPH:   next_io_rdata = next_sp[15:8];
         IES_ADR_FLAGS: next_io_rdata = next_flags;
         IES_ADR_PEND:  next_io_rdata = 8'(next_pend);
         default:       next_io_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         state          <= IES_ST_IDLE;
         cnt            <= IES_CNT_RST;
         sp             <= TOP & SP_MASK;
         flags          <= IES_FLAGS_RST;
         pend           <= IES_PEND_RST;
         hold_off       <= 1'b0;
         is_call        <= 1'b0;
         is_irq_exit_instruction        <= 1'b0;
         sel            <= '0;
         pc_save        <= 16'h0000;
         pc_hi          <= 8'h00;
         o_mem          <= IES_MEM_IDLE;
         o_pc_load      <= 1'b0;
         o_pc_value     <= 16'h0000;
         o_io_rdata     <= 8'h00;
         o_busy         <= 1'b0;
         o_gie          <= 1'b0;
         o_sp           <= TOP & SP_MASK;
         o_flag_pending <= IES_PEND_RST;
      end else if (i_clk_en) begin
         state          <= next_state;
         cnt            <= next_cnt;
         sp             <= next_sp;
         flags          <= next_flags;
         pend           <= next_pend;
         hold_off       <= next_hold_off;
         is_call        <= next_is_call;
         is_irq_exit_instruction        <= next_is_irq_exit_instruction;
         sel            <= next_sel;
         pc_save        <= next_pc_save;
         pc_hi          <= next_pc_hi;
         o_mem          <= next_mem;
         o_pc_load      <= next_pc_load;
         o_pc_value     <= next_pc_value;
         o_io_rdata     <= next_io_rdata;
         o_busy         <= (next_state != IES_ST_IDLE);
         o_gie          <= next_flags[IES_GIE_BIT];
         o_sp           <= next_sp;
         o_flag_pending <= next_pend;
      end
   end
endmodule
`default_nettype wire

// ==== ies_stack_mem.sv ====
// stack memory model on the far side of the unit's memory strobes
`timescale 1ns/1ps
`default_nettype none
module ies_stack_mem
   import ies_pkg::*;
(
   input  wire logic     i_sys_clk,
   input  wire ies_mem_s i_mem,
   output logic [7:0]    o_rdata
);
   logic [7:0] mem [0:1023];
   initial o_rdata = 8'h00;
   // read data shows the cycle after the strobe
   always @(posedge i_sys_clk) begin
      if (i_mem.we) mem[i_mem.addr[9:0]] <= i_mem.wdata;
      // no read due: bus scrambled rather than held
      o_rdata <= i_mem.re ? mem[i_mem.addr[9:0]] : ~o_rdata;
   end
endmodule
`default_nettype wire

// ==== ies_irq_sp_props.sv ====
// checker of stack pointer moves and interrupt sequencing
`timescale 1ns/1ps
`default_nettype none
module ies_irq_sp_props
   import ies_pkg::*;
(
   input wire logic              i_sys_clk,
   input wire logic              i_resetn,
   input wire ies_cmd_e          i_cmd,
   input wire logic              i_insn_done,
   input wire logic              i_io_wr,
   input wire logic [5:0]        i_io_addr,
   input wire logic [7:0]        i_io_wdata,
   input wire logic [IES_NF-1:0] i_flag_cond,
   input wire ies_mem_s          o_mem,
   input wire logic              o_pc_load,
   input wire logic              o_busy,
   input wire logic              o_gie,
   input wire logic [15:0]       o_sp,
   input wire logic [IES_NF-1:0] o_flag_pending
);
   logic [1:0] rel;
   logic       run;
   logic       idle;
   // edges since reset release, saturating
   always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rel <= 2'h0;
      end else if (rel != 2'h3) begin
         rel <= rel + 2'h1;
      end
   end
   assign run  = rel == 2'h3;
   assign idle = run && !o_busy && !i_insn_done;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   property p_push;
      idle && i_cmd == IES_CMD_PUSH1 |=>
         o_mem.we && o_mem.addr == $past(o_sp) && o_sp == $past(o_sp) - 16'h0001;
   endproperty
   a_push: assert property (p_push) else $error("push moved sp wrongly");
   property p_pop;
      idle && i_cmd == IES_CMD_POP1 |=> o_mem.re && o_sp == $past(o_sp) + 16'h0001;
   endproperty
   a_pop: assert property (p_pop) else $error("pop moved sp wrongly");
   property p_call;
      idle && i_cmd == IES_CMD_CALL |-> ##3 o_sp == $past(o_sp, 3) - 16'h0002;
   endproperty
   a_call: assert property (p_call) else $error("call moved sp wrongly");
   property p_ret;
      idle && i_cmd == IES_CMD_RET |-> ##5 o_pc_load && o_sp == $past(o_sp, 5) + 16'h0002;
   endproperty
   a_ret: assert property (p_ret) else $error("return sp or timing wrong");
   property p_irq_exit_instruction;
      idle && i_cmd == IES_CMD_IRQ_EXIT_INSTRUCTION |-> ##5 o_pc_load && o_gie;
   endproperty
   a_irq_exit_instruction: assert property (p_irq_exit_instruction) else $error("irq exit gie or timing wrong");
   property p_entry;
      $rose(o_busy) && $past(i_insn_done) && $past(i_cmd) == IES_CMD_NONE && $past(o_gie) |->
         !o_gie && !o_pc_load ##1 !o_pc_load [*3] ##1 o_pc_load;
   endproperty
   a_entry: assert property (p_entry) else $error("entry gie or length wrong");
   property p_cli;
      run && !o_busy && i_cmd == IES_CMD_CLI && !i_io_wr |=> !o_gie && !o_busy;
   endproperty
   a_cli: assert property (p_cli) else $error("request taken with disable");
   property p_wclr;
      run && i_io_wr && i_io_addr == IES_ADR_PEND |=>
         (o_flag_pending & $past(i_io_wdata & ~i_flag_cond)) == 8'h00;
   endproperty
   a_wclr: assert property (p_wclr) else $error("pending not cleared by one");
   property p_fset;
      run && i_flag_cond != 8'h00 |=>
         (o_flag_pending & $past(i_flag_cond)) == $past(i_flag_cond);
   endproperty
   a_fset: assert property (p_fset) else $error("event did not set pending");
   c_entry: cover property (o_pc_load && !o_gie);
   c_irq_exit_instruction: cover property (idle && i_cmd == IES_CMD_IRQ_EXIT_INSTRUCTION);
   c_wclr: cover property (i_io_wr && i_io_addr == IES_ADR_PEND);
endmodule
bind ies_irq_sp ies_irq_sp_props ies_irq_sp_props_inst (.i_sys_clk, .i_resetn, .i_cmd,
   .i_insn_done, .i_io_wr, .i_io_addr, .i_io_wdata, .i_flag_cond, .o_mem, .o_pc_load,
   .o_busy, .o_gie, .o_sp, .o_flag_pending);
`default_nettype wire

// ==== ies_irq_sp_tb.sv ====
// testbench of the interrupt entry and stack pointer unit
`timescale 1ns/1ps
`default_nettype none
module ies_irq_sp_tb
   import ies_pkg::*;
;
   logic        i_sys_clk, i_resetn, i_insn_done, i_io_wr, i_lock_fuse_one, i_pc_in_locked_area;
   logic        i_lock_fuse_two, i_sleeping;
   logic        o_pc_load, o_busy, o_gie;
   ies_cmd_e    i_cmd;
   ies_mem_s    o_mem;
   logic [15:0] i_pc, o_pc_value, o_sp, sp;
   logic [7:0]  i_push_data, i_flag_cond, i_flag_en, i_io_wdata, i_mem_rdata, o_io_rdata, rd;
   logic [7:0]  o_flag_pending;
   logic [3:0]  i_level_cond, i_level_en;
   logic [5:0]  i_io_addr;
   int          n_errors = 0, cmp_count = 0, n;
   ies_irq_sp #(.SP_W(16), .TOP(IES_TOP_OF_DATA_MEMORY)) ies_irq_sp_inst (
      .i_sys_clk, .i_resetn, .i_clk_en(1'b1), .i_cmd, .i_insn_done, .i_sleeping,
      .i_pc, .i_push_data, .i_flag_cond, .i_flag_en, .i_level_cond, .i_level_en,
      .i_lock_fuse_one, .i_lock_fuse_two, .i_pc_in_locked_area, .i_io_wr, .i_io_addr,
      .i_io_wdata, .i_mem_rdata, .o_io_rdata, .o_mem, .o_pc_load, .o_pc_value, .o_busy,
      .o_gie, .o_sp, .o_flag_pending);
   ies_stack_mem ies_stack_mem_inst (.i_sys_clk, .i_mem(o_mem), .o_rdata(i_mem_rdata));
   always #10 i_sys_clk = ~i_sys_clk;
   task automatic tick(input int k);
      repeat (k) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [15:0] m(input logic [15:0] a);
      return {8'h00, ies_stack_mem_inst.mem[a[9:0]]};
   endfunction
   task automatic issue(input ies_cmd_e c);
      i_cmd = c;
      tick(1);
      i_cmd = IES_CMD_NONE;
   endtask
   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      i_io_wr = 1'b1;
      i_io_addr = a;
      i_io_wdata = d;
      tick(1);
      i_io_wr = 1'b0;
      tick(1);
   endtask
   task automatic io_rd(input logic [5:0] a);
      i_io_addr = a;
      tick(1);
      rd = o_io_rdata;
   endtask
   task automatic done1;
      i_insn_done = 1'b1;
      tick(1);
      i_insn_done = 1'b0;
   endtask
   // edges from the taking edge to the pc load, then one more
   task automatic wait_load;
      n = 1;
      while (o_pc_load !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      tick(1);
   endtask
   task automatic t_reset;
      chk("sp", IES_TOP_OF_DATA_MEMORY, o_sp);
      io_rd(IES_ADR_SPL);
      chk("spl", {8'h00, IES_TOP_OF_DATA_MEMORY[7:0]}, {8'h00, rd});
      io_rd(IES_ADR_SPH);
      chk("sph", {8'h00, IES_TOP_OF_DATA_MEMORY[15:8]}, {8'h00, rd});
      sp = 16'h01F0;
      io_wr(IES_ADR_SPL, sp[7:0]);
      io_wr(IES_ADR_SPH, sp[15:8]);
      chk("sp wr", sp, o_sp);
   endtask
   task automatic t_stack;
      i_push_data = 8'hA5;
      i_cmd = IES_CMD_PUSH1;
      tick(1);
      chk("push sp", sp - 16'h0001, o_sp);
      i_cmd = IES_CMD_POP1;
      tick(1);
      i_cmd = IES_CMD_NONE;
      chk("push data", 16'h00A5, m(sp));
      chk("pop sp", sp, o_sp);
      chk("pop adr", sp, o_mem.addr);
      i_pc = 16'h0123;
      issue(IES_CMD_CALL);
      tick(2);
      chk("call sp", sp - 16'h0002, o_sp);
      tick(4);
      chk("call lo", 16'h0023, m(sp));
      chk("call hi", 16'h0001, m(sp - 16'h0001));
      issue(IES_CMD_RET);
      wait_load;
      chk("ret cyc", 16'h0005, 16'(n));
      chk("ret pc", 16'h0123, o_pc_value);
      chk("ret sp", sp, o_sp);
   endtask
   task automatic t_irq;
      io_wr(IES_ADR_FLAGS, 8'h03);
      i_flag_cond = 8'h28;
      tick(1);
      i_flag_cond = 8'h00;
      done1;
      tick(2);
      chk("held", 16'h0028, {8'h00, o_flag_pending});
      chk("gie off", 16'h0000, {15'h0000, o_busy});
      i_flag_en = 8'h28;
      i_pc = 16'h0456;
      issue(IES_CMD_SEI);
      i_insn_done = 1'b1;
      tick(1);
      chk("after sei", 16'h0000, {15'h0000, o_busy});
      tick(1);
      i_insn_done = 1'b0;
      wait_load;
      chk("entry cyc", 16'h0005, 16'(n));
      chk("vec3", IES_VEC_BASE + IES_VEC_STEP * 16'h0004, o_pc_value);
      chk("one served", 16'h0020, {8'h00, o_flag_pending});
      chk("entry lo", 16'h0056, m(sp));
      chk("entry hi", 16'h0004, m(sp - 16'h0001));
      io_rd(IES_ADR_FLAGS);
      chk("flags", 16'h0003, {8'h00, rd});
      issue(IES_CMD_IRQ_EXIT_INSTRUCTION);
      wait_load;
      chk("irq_exit_instruction cyc", 16'h0005, 16'(n));
      chk("irq_exit_instruction pc", 16'h0456, o_pc_value);
      chk("irq_exit_instruction sp", sp, o_sp);
      chk("irq_exit_instruction gie", 16'h0001, {15'h0000, o_gie});
      i_insn_done = 1'b1;
      tick(1);
      chk("one more", 16'h0000, {15'h0000, o_busy});
      tick(1);
      i_insn_done = 1'b0;
      wait_load;
      chk("vec5", IES_VEC_BASE + IES_VEC_STEP * 16'h0006, o_pc_value);
      chk("pend", 16'h0000, {8'h00, o_flag_pending});
      issue(IES_CMD_IRQ_EXIT_INSTRUCTION);
      wait_load;
   endtask
   task automatic t_clr_cli;
      i_flag_cond = 8'h81;
      tick(1);
      i_flag_cond = 8'h00;
      io_wr(IES_ADR_PEND, 8'h01);
      chk("w1c", 16'h0080, {8'h00, o_flag_pending});
      io_wr(IES_ADR_PEND, 8'h00);
      chk("w0", 16'h0080, {8'h00, o_flag_pending});
      i_flag_en = 8'hA8;
      done1;
      tick(1);
      i_cmd = IES_CMD_CLI;
      done1;
      i_cmd = IES_CMD_NONE;
      chk("cli gie", 16'h0000, {15'h0000, o_gie});
      tick(3);
      chk("cli busy", 16'h0000, {15'h0000, o_busy});
      io_wr(IES_ADR_PEND, 8'h80);
   endtask
   task automatic t_level;
      i_level_cond = 4'h1;
      tick(2);
      i_level_cond = 4'h0;
      i_level_en = 4'h1;
      issue(IES_CMD_SEI);
      done1;
      tick(1);
      done1;
      tick(3);
      chk("gone", 16'h0000, {15'h0000, o_busy});
      i_lock_fuse_one = 1'b1;
      i_pc_in_locked_area = 1'b1;
      i_level_cond = 4'h1;
      tick(1);
      done1;
      tick(3);
      chk("locked", 16'h0000, {15'h0000, o_busy});
      i_lock_fuse_one = 1'b0;
      i_lock_fuse_two = 1'b1;
      done1;
      tick(3);
      chk("locked two", 16'h0000, {15'h0000, o_busy});
      i_pc_in_locked_area = 1'b0;
      done1;
      wait_load;
      chk("vec8", IES_VEC_BASE + IES_VEC_STEP * 16'h0009, o_pc_value);
   endtask
   // wake from sleep: entry edges counted from the wake edge
   task automatic t_sleep;
      i_level_cond = 4'h0;
      issue(IES_CMD_IRQ_EXIT_INSTRUCTION);
      wait_load;
      done1;
      i_flag_cond = 8'h08;
      tick(1);
      i_flag_cond = 8'h00;
      chk("no wake busy", 16'h0000, {15'h0000, o_busy});
      i_sleeping = 1'b1;
      tick(1);
      i_sleeping = 1'b0;
      wait_load;
      chk("wake cyc", 16'h0009, 16'(n));
      chk("wake vec3", IES_VEC_BASE + IES_VEC_STEP * 16'h0004, o_pc_value);
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      {i_sys_clk, i_resetn, i_insn_done, i_io_wr, i_lock_fuse_one, i_pc_in_locked_area} = '0;
      {i_pc, i_push_data, i_flag_cond, i_flag_en, i_io_wdata, i_level_cond, i_level_en} = '0;
      {i_lock_fuse_two, i_sleeping} = 2'b00;
      i_io_addr = 6'h00;
      i_cmd = IES_CMD_NONE;
      tick(10);
      i_resetn = 1'b1;
      tick(4);
      t_reset;
      t_stack;
      t_irq;
      t_clr_cli;
      t_level;
      t_sleep;
      stop_test;
   end
   // the scenarios need about 125 cycles
   initial begin
      #100000;
      n_errors++;
      stop_test;
   end
endmodule
`default_nettype wire
